/* File: hw/ddrmc_ctrl.v */
`timescale 1ns/1ps
// Functional notes
// - override 01 forces channel 1 bufferable
// - override 10 forces channel 1 non-bufferable, 00 and 11 follow the hprot input
// - split-off bit stops channel 1 split responses
// - split-off only matters for enabled split channel
// - zq code 01 issues zqcs after self-refresh
// - zq code 10 issues zqcl after self-refresh
// - other zq codes issue no zq command
// - zq command waits trfc plus 10 ns
// - write-level recalibration every n times 1024 cycles
// - dll update every n times 1024 cycles
// - three-bit field selects phy drive impedance
// - per-lane pass bits read at 25, 24
// - bits 17, 16 pick software or hardware leveling
// - eight-bit wait from dqs to dq sample
// - write leveling only in ddr3 mode
// - leveling aligns dqs to fly-by clock skew
`include "ddrmc_map.vh"
module ddrmc_ctrl #(
	parameter TRFC_NS     = 160,
	parameter UPDATE_UNIT = `DDRMC_UPDATE_UNIT,
	parameter DW          = 7
) (
	input  wire          CLK,
	input  wire          RST,
	input  wire          CYC_I,
	input  wire          STB_I,
	input  wire          WE_I,
	input  wire [7:0]    ADR_I,
	input  wire [3:0]    SEL_I,
	input  wire [31:0]   DAT_I,
	output reg  [31:0]   DAT_O,
	output reg           ACK_O,
	input  wire          DDR3_MODE,
	input  wire          CH1_ENABLE,
	input  wire          CH1_SPLIT_CAP,
	input  wire          CH1_HPROT_BUF,
	input  wire          SR_EXIT,
	input  wire [1:0]    WL_DQ_FB,
	output reg           CH1_BUFFERABLE,
	output reg           CH1_SPLIT_EN,
	output reg           ZQCS_REQ,
	output reg           ZQCL_REQ,
	output reg           DLL_UPD_REQ,
	output reg  [2:0]    PHY_DRIVE,
	output wire [1:0]    WL_DQS_EN,
	output wire [1:0]    WL_BUSY,
	output wire [DW-1:0] LANE0_DELAY,
	output wire [DW-1:0] LANE1_DELAY
);
	localparam TXS_NS     = TRFC_NS + `DDRMC_TXS_EXTRA_NS;
	localparam TXS_CYC    = (TXS_NS + `DDRMC_CLK_PERIOD_NS - 1) / `DDRMC_CLK_PERIOD_NS;
	localparam TXS_CYC_C  = (TXS_CYC < 1) ? 1 : TXS_CYC;
	localparam UNIT_MAX   = UPDATE_UNIT - 1;

	// byte-lane merge of a wishbone write into a register word
	function [31:0] wb_merge;
		input [31:0] old;
		input [31:0] wdat;
		input [3:0]  sel;
		integer i;
		begin
			wb_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					wb_merge[i*8 +: 8] = wdat[i*8 +: 8];
				end
			end
		end
	endfunction

	// interval counter step: counts units, wraps when it reaches n
	function [8:0] iv_step;
		input [7:0] cnt;
		input [7:0] n;
		input       tick;
		begin
			if (n == 8'h00) begin
				iv_step = 9'h000;
			end else if (!tick) begin
				iv_step = {1'b0, cnt};
			end else if (cnt + 8'h01 >= n) begin
				iv_step = 9'h100;
			end else begin
				iv_step = {1'b0, cnt + 8'h01};
			end
		end
	endfunction

	reg  [1:0]  prot_ovr_r;
	reg         split_off_r;
	reg  [1:0]  zq_mode_r;
	reg  [7:0]  wl_iv_r;
	reg  [7:0]  dll_iv_r;
	reg  [2:0]  drive_r;
	reg  [1:0]  sw_scan_r;
	reg  [7:0]  wlo_r;

	reg  [31:0] split_word;
	reg  [31:0] update_word;
	reg  [31:0] drive_word;
	reg  [31:0] wlctrl_word;
	reg  [31:0] rd_nxt;
	reg         hit;

	reg  [1:0]  fb_s1_r;
	reg  [1:0]  fb_s2_r;
	reg  [1:0]  fb_s3_r;
	reg  [1:0]  fb_r;

	reg  [31:0] unit_cnt_r;
	reg         unit_tick_r;
	reg  [7:0]  wl_cnt_r;
	reg  [7:0]  dll_cnt_r;
	reg         wl_start_r;
	reg  [31:0] zq_cnt_r;
	reg         zq_wait_r;
	reg  [1:0]  zq_kind_r;

	wire        acc = CYC_I & STB_I & ~ACK_O;
	// a write lands on the edge at which the master sees ack, not at the take
	wire        wr  = CYC_I & STB_I & WE_I & ACK_O;
	wire [7:0]  word_adr = {ADR_I[7:2], 2'b00};
	wire [1:0]  lane_passed;
	wire [8:0]  wl_step  = iv_step(wl_cnt_r, wl_iv_r, unit_tick_r);
	wire [8:0]  dll_step = iv_step(dll_cnt_r, dll_iv_r, unit_tick_r);
	wire        wl_written = wr && (word_adr == `DDRMC_OFS_WLCTRL);

	always @* begin
		split_word  = 32'h00000000;
		split_word[`DDRMC_PROT_MSB:`DDRMC_PROT_LSB] = prot_ovr_r;
		split_word[`DDRMC_SPLIT_OFF_BIT] = split_off_r;
		update_word = 32'h00000000;
		update_word[`DDRMC_ZQ_MSB:`DDRMC_ZQ_LSB]       = zq_mode_r;
		update_word[`DDRMC_WLIV_MSB:`DDRMC_WLIV_LSB]   = wl_iv_r;
		update_word[`DDRMC_DLLIV_MSB:`DDRMC_DLLIV_LSB] = dll_iv_r;
		drive_word  = 32'h00000000;
		drive_word[`DDRMC_DRV_MSB:`DDRMC_DRV_LSB] = drive_r;
		wlctrl_word = 32'h00000000;
		// pass reads 0 for a lane under software scan
		wlctrl_word[`DDRMC_WL_PASS0_BIT] = lane_passed[0] & ~sw_scan_r[0];
		wlctrl_word[`DDRMC_WL_PASS1_BIT] = lane_passed[1] & ~sw_scan_r[1];
		wlctrl_word[`DDRMC_WL_SW0_BIT]   = sw_scan_r[0];
		wlctrl_word[`DDRMC_WL_SW1_BIT]   = sw_scan_r[1];
		wlctrl_word[`DDRMC_WLO_MSB:`DDRMC_WLO_LSB] = wlo_r;
		hit    = 1'b1;
		if (word_adr == `DDRMC_OFS_SPLIT) begin
			rd_nxt = split_word;
		end else if (word_adr == `DDRMC_OFS_UPDATE) begin
			rd_nxt = update_word;
		end else if (word_adr == `DDRMC_OFS_DRIVE) begin
			rd_nxt = drive_word;
		end else if (word_adr == `DDRMC_OFS_WLCTRL) begin
			rd_nxt = wlctrl_word;
		end else begin
			rd_nxt = 32'h00000000;
			hit    = 1'b0;
		end
	end

	// wishbone slave: ack one cycle after the request, unmapped reads 0
	always @(posedge CLK) begin
		if (RST) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h00000000;
		end else begin
			ACK_O <= acc;
			if (acc && !WE_I) begin
				DAT_O <= hit ? rd_nxt : 32'h00000000;
			end
		end
	end

	reg [31:0] m_split;
	reg [31:0] m_update;
	reg [31:0] m_drive;
	reg [31:0] m_wl;

	always @* begin
		m_split  = wb_merge(split_word, DAT_I, SEL_I);
		m_update = wb_merge(update_word, DAT_I, SEL_I);
		m_drive  = wb_merge(drive_word, DAT_I, SEL_I);
		m_wl     = wb_merge(wlctrl_word, DAT_I, SEL_I);
	end

	always @(posedge CLK) begin
		if (RST) begin
			prot_ovr_r  <= 2'b00;
			split_off_r <= 1'b0;
			zq_mode_r   <= 2'b00;
			wl_iv_r     <= 8'h00;
			dll_iv_r    <= 8'h00;
			drive_r     <= `DDRMC_DRV_RESET;
			sw_scan_r   <= 2'b00;
			wlo_r       <= `DDRMC_WLO_RESET;
		end else if (wr) begin
			if (word_adr == `DDRMC_OFS_SPLIT) begin
				prot_ovr_r  <= m_split[`DDRMC_PROT_MSB:`DDRMC_PROT_LSB];
				split_off_r <= m_split[`DDRMC_SPLIT_OFF_BIT];
			end else if (word_adr == `DDRMC_OFS_UPDATE) begin
				zq_mode_r <= m_update[`DDRMC_ZQ_MSB:`DDRMC_ZQ_LSB];
				wl_iv_r   <= m_update[`DDRMC_WLIV_MSB:`DDRMC_WLIV_LSB];
				dll_iv_r  <= m_update[`DDRMC_DLLIV_MSB:`DDRMC_DLLIV_LSB];
			end else if (word_adr == `DDRMC_OFS_DRIVE) begin
				drive_r <= m_drive[`DDRMC_DRV_MSB:`DDRMC_DRV_LSB];
			end else if (word_adr == `DDRMC_OFS_WLCTRL) begin
				sw_scan_r[0] <= m_wl[`DDRMC_WL_SW0_BIT];
				sw_scan_r[1] <= m_wl[`DDRMC_WL_SW1_BIT];
				wlo_r        <= m_wl[`DDRMC_WLO_MSB:`DDRMC_WLO_LSB];
			end
		end
	end

	// channel 1 protection and split control
	always @(posedge CLK) begin
		if (RST) begin
			CH1_BUFFERABLE <= 1'b0;
			CH1_SPLIT_EN   <= 1'b0;
			PHY_DRIVE      <= `DDRMC_DRV_RESET;
		end else begin
			if (prot_ovr_r == `DDRMC_PROT_FORCE_BUF) begin
				CH1_BUFFERABLE <= 1'b1;
			end else if (prot_ovr_r == `DDRMC_PROT_FORCE_NOBUF) begin
				CH1_BUFFERABLE <= 1'b0;
			end else begin
				CH1_BUFFERABLE <= CH1_HPROT_BUF;
			end
			CH1_SPLIT_EN <= CH1_ENABLE & CH1_SPLIT_CAP & ~split_off_r;
			PHY_DRIVE    <= drive_r;
		end
	end

	// dq feedback from the dram: three stages, accept when stages 2 and 3 agree
	always @(posedge CLK) begin
		if (RST) begin
			fb_s1_r <= 2'b00;
			fb_s2_r <= 2'b00;
			fb_s3_r <= 2'b00;
			fb_r    <= 2'b00;
		end else begin
			fb_s1_r <= WL_DQ_FB;
			fb_s2_r <= fb_s1_r;
			fb_s3_r <= fb_s2_r;
			if (fb_s2_r[0] == fb_s3_r[0]) begin
				fb_r[0] <= fb_s3_r[0];
			end
			if (fb_s2_r[1] == fb_s3_r[1]) begin
				fb_r[1] <= fb_s3_r[1];
			end
		end
	end

	// 1024-cycle unit prescaler and the two interval counters
	always @(posedge CLK) begin
		if (RST) begin
			unit_cnt_r  <= 32'h00000000;
			unit_tick_r <= 1'b0;
			wl_cnt_r    <= 8'h00;
			dll_cnt_r   <= 8'h00;
			wl_start_r  <= 1'b0;
			DLL_UPD_REQ <= 1'b0;
		end else begin
			if (unit_cnt_r == UNIT_MAX) begin
				unit_cnt_r  <= 32'h00000000;
				unit_tick_r <= 1'b1;
			end else begin
				unit_cnt_r  <= unit_cnt_r + 32'h00000001;
				unit_tick_r <= 1'b0;
			end
			wl_cnt_r    <= wl_step[7:0];
			dll_cnt_r   <= dll_step[7:0];
			DLL_UPD_REQ <= dll_step[8];
			// in ddr3 mode a write to the leveling register also starts a scan
			wl_start_r  <= DDR3_MODE & (wl_step[8] | wl_written);
		end
	end

	// zq calibration after self-refresh exit, held off until txs
	always @(posedge CLK) begin
		if (RST) begin
			zq_cnt_r  <= 32'h00000000;
			zq_wait_r <= 1'b0;
			zq_kind_r <= 2'b00;
			ZQCS_REQ  <= 1'b0;
			ZQCL_REQ  <= 1'b0;
		end else begin
			ZQCS_REQ <= 1'b0;
			ZQCL_REQ <= 1'b0;
			if (SR_EXIT && (zq_mode_r == `DDRMC_ZQ_SHORT || zq_mode_r == `DDRMC_ZQ_LONG)) begin
				zq_wait_r <= 1'b1;
				zq_kind_r <= zq_mode_r;
				zq_cnt_r  <= TXS_CYC_C;
			end else if (zq_wait_r) begin
				if (zq_cnt_r == 32'h00000001) begin
					zq_wait_r <= 1'b0;
					ZQCS_REQ  <= (zq_kind_r == `DDRMC_ZQ_SHORT);
					ZQCL_REQ  <= (zq_kind_r == `DDRMC_ZQ_LONG);
				end else begin
					zq_cnt_r <= zq_cnt_r - 32'h00000001;
				end
			end
		end
	end

	// per-lane hardware scan; a lane under software scan stays idle
	ddrmc_lane_wl #(
		.DW (DW)
	) u_lane0 (
		.clk        (CLK),
		.rst        (RST),
		.start      (wl_start_r),
		.enable     (~sw_scan_r[0] & DDR3_MODE),
		.sample_dly (wlo_r),
		.dq_fb      (fb_r[0]),
		.busy_r     (WL_BUSY[0]),
		.dqs_en_r   (WL_DQS_EN[0]),
		.delay_r    (LANE0_DELAY),
		.passed_r   (lane_passed[0])
	);

	ddrmc_lane_wl #(
		.DW (DW)
	) u_lane1 (
		.clk        (CLK),
		.rst        (RST),
		.start      (wl_start_r),
		.enable     (~sw_scan_r[1] & DDR3_MODE),
		.sample_dly (wlo_r),
		.dq_fb      (fb_r[1]),
		.busy_r     (WL_BUSY[1]),
		.dqs_en_r   (WL_DQS_EN[1]),
		.delay_r    (LANE1_DELAY),
		.passed_r   (lane_passed[1])
	);
endmodule

/* File: shared/ddrmc_map.vh */
`ifndef DDRMC_MAP_VH
`define DDRMC_MAP_VH

// register byte offsets
`define DDRMC_OFS_SPLIT     8'h48
`define DDRMC_OFS_UPDATE    8'h4c
`define DDRMC_OFS_DRIVE     8'h5c
`define DDRMC_OFS_WLCTRL    8'h60

// ahb_split_protect_ctrl fields
`define DDRMC_SPLIT_OFF_BIT 1
`define DDRMC_PROT_LSB      8
`define DDRMC_PROT_MSB      9
`define DDRMC_PROT_FORCE_BUF   2'b01
`define DDRMC_PROT_FORCE_NOBUF 2'b10

// update_interval_ctrl fields
`define DDRMC_ZQ_LSB        16
`define DDRMC_ZQ_MSB        17
`define DDRMC_ZQ_SHORT      2'b01
`define DDRMC_ZQ_LONG       2'b10
`define DDRMC_WLIV_LSB      8
`define DDRMC_WLIV_MSB      15
`define DDRMC_DLLIV_LSB     0
`define DDRMC_DLLIV_MSB     7

// phy_drive_strength fields
`define DDRMC_DRV_LSB       0
`define DDRMC_DRV_MSB       2
`define DDRMC_DRV_RESET     3'h7

// write_level_ctrl fields
`define DDRMC_WL_PASS0_BIT  24
`define DDRMC_WL_PASS1_BIT  25
`define DDRMC_WL_SW0_BIT    16
`define DDRMC_WL_SW1_BIT    17
`define DDRMC_WLO_LSB       0
`define DDRMC_WLO_MSB       7
`define DDRMC_WLO_RESET     8'h0a

// timing
`define DDRMC_CLK_PERIOD_NS 100
`define DDRMC_TXS_EXTRA_NS  10
`define DDRMC_UPDATE_UNIT   1024

`endif

/* File: hw/ddrmc_lane_wl.v */
`timescale 1ns/1ps
// one byte lane of the hardware write-leveling scan
module ddrmc_lane_wl #(
	parameter DW = 7
) (
	input  wire          clk,
	input  wire          rst,
	input  wire          start,
	input  wire          enable,
	input  wire [7:0]    sample_dly,
	input  wire          dq_fb,
	output reg           busy_r,
	output reg           dqs_en_r,
	output reg  [DW-1:0] delay_r,
	output reg           passed_r
);
	localparam S_IDLE = 2'd0;
	localparam S_SET  = 2'd1;
	localparam S_WAIT = 2'd2;

	reg [1:0] state_r;
	reg [7:0] cnt_r;
	reg       seen_low_r;

	always @(posedge clk) begin
		if (rst) begin
			state_r    <= S_IDLE;
			cnt_r      <= 8'h00;
			seen_low_r <= 1'b0;
			busy_r     <= 1'b0;
			dqs_en_r   <= 1'b0;
			delay_r    <= {DW{1'b0}};
			passed_r   <= 1'b0;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (start) begin
					passed_r <= 1'b0;
					if (enable) begin
						state_r    <= S_SET;
						busy_r     <= 1'b1;
						delay_r    <= {DW{1'b0}};
						seen_low_r <= 1'b0;
					end
				end
			end
			S_SET: begin
				// dqs pulse at the current delay; dq sampled after the set wait
				dqs_en_r <= 1'b1;
				cnt_r    <= (sample_dly == 8'h00) ? 8'h01 : sample_dly;
				state_r  <= S_WAIT;
			end
			S_WAIT: begin
				if (cnt_r == 8'h01) begin
					dqs_en_r <= 1'b0;
					if (dq_fb && seen_low_r) begin
						passed_r <= 1'b1;
						busy_r   <= 1'b0;
						state_r  <= S_IDLE;
					end else if (delay_r == {DW{1'b1}}) begin
						busy_r  <= 1'b0;
						state_r <= S_IDLE;
					end else begin
						seen_low_r <= seen_low_r | ~dq_fb;
						delay_r    <= delay_r + {{(DW-1){1'b0}}, 1'b1};
						state_r    <= S_SET;
					end
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: tb/ddrmc_checker.sv */
`timescale 1ns/1ps
module ddrmc_checker #(
	parameter TRFC_NS     = 160,
	parameter UPDATE_UNIT = 8
) (
	input wire        CLK,
	input wire        RST,
	input wire        CYC_I,
	input wire        STB_I,
	input wire        WE_I,
	input wire [7:0]  ADR_I,
	input wire [3:0]  SEL_I,
	input wire [31:0] DAT_I,
	input wire        ACK_O,
	input wire        DDR3_MODE,
	input wire        CH1_ENABLE,
	input wire        CH1_SPLIT_CAP,
	input wire        CH1_HPROT_BUF,
	input wire        SR_EXIT,
	input wire        CH1_BUFFERABLE,
	input wire        CH1_SPLIT_EN,
	input wire        ZQCS_REQ,
	input wire        ZQCL_REQ,
	input wire        DLL_UPD_REQ,
	input wire [2:0]  PHY_DRIVE,
	input wire [1:0]  WL_DQS_EN,
	input wire [1:0]  WL_BUSY
);
	reg  [1:0] ov_r;
	reg        soff_r;
	wire       take = CYC_I && STB_I && WE_I && ACK_O;
	wire       wr48 = take && ADR_I[7:2] == 6'h12;
	wire       wr5c = take && ADR_I[7:2] == 6'h17;
	wire       buf_exp = ov_r == 2'h1 || (ov_r != 2'h2 && CH1_HPROT_BUF);
	wire       split_exp = CH1_ENABLE && CH1_SPLIT_CAP && !soff_r;
	// shadow of the channel-1 control fields seen on the bus
	always @(posedge CLK) begin
		if (RST) begin
			ov_r <= 2'h0;
			soff_r <= 1'h0;
		end else begin
			if (wr48 && SEL_I[1])
				ov_r <= DAT_I[9:8];
			if (wr48 && SEL_I[0])
				soff_r <= DAT_I[1];
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	ack_latency_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("bus request not answered next cycle");
	ack_pulse_a: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	prot_buf_a: assert property (!$past(RST) |-> CH1_BUFFERABLE == $past(buf_exp))
		else $error("channel 1 bufferable wrong");
	split_gate_a: assert property (!$past(RST) |-> CH1_SPLIT_EN == $past(split_exp))
		else $error("channel 1 split enable wrong");
	zq_delay_a: assert property (ZQCS_REQ || ZQCL_REQ |-> $past(SR_EXIT, 2) || $past(SR_EXIT, 3))
		else $error("zq command not spaced from self-refresh exit");
	dll_space_a: assert property (DLL_UPD_REQ |=> (!DLL_UPD_REQ) [*7])
		else $error("dll updates closer than one unit");
	drive_write_a: assert property ($changed(PHY_DRIVE) |-> $past(wr5c) || $past(wr5c, 2))
		else $error("drive changed without a write");
	level_ddr3_a: assert property ($rose(|WL_BUSY) |-> $past(DDR3_MODE) || $past(DDR3_MODE, 2))
		else $error("leveling started outside ddr3 mode");
	dqs_in_scan_a: assert property (!(|(WL_DQS_EN & ~WL_BUSY)))
		else $error("dqs pulse outside a scan");
	cover property (ZQCL_REQ);
	cover property (DLL_UPD_REQ);
	cover property ($fell(WL_BUSY[0]));
endmodule

bind ddrmc_ctrl ddrmc_checker #(.TRFC_NS(TRFC_NS), .UPDATE_UNIT(UPDATE_UNIT)) u_chk (
	.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
	.SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O), .DDR3_MODE(DDR3_MODE),
	.CH1_ENABLE(CH1_ENABLE), .CH1_SPLIT_CAP(CH1_SPLIT_CAP), .CH1_HPROT_BUF(CH1_HPROT_BUF),
	.SR_EXIT(SR_EXIT), .CH1_BUFFERABLE(CH1_BUFFERABLE), .CH1_SPLIT_EN(CH1_SPLIT_EN),
	.ZQCS_REQ(ZQCS_REQ), .ZQCL_REQ(ZQCL_REQ), .DLL_UPD_REQ(DLL_UPD_REQ),
	.PHY_DRIVE(PHY_DRIVE), .WL_DQS_EN(WL_DQS_EN), .WL_BUSY(WL_BUSY));

/* File: tb/ddrmc_dram_model.sv */
`timescale 1ns/1ps
module ddrmc_dram_model #(
	parameter TH0 = 20,
	parameter TH1 = 45
) (
	input  wire       lclk,
	input  wire [1:0] dqs_en,
	input  wire [6:0] dly0,
	input  wire [6:0] dly1,
	input  wire [1:0] dead,
	output reg  [1:0] fb
);
	initial fb = 2'h1;
	// dq reports the clock level only while dqs runs, and wanders otherwise
	always @(posedge lclk) begin
		fb[0] <= dqs_en[0] ? !dead[0] && dly0 >= TH0 : !fb[0];
		fb[1] <= dqs_en[1] ? !dead[1] && dly1 >= TH1 : !fb[1];
	end
endmodule

/* File: tb/ddrmc_ctrl_bench.sv */
`timescale 1ns/1ps
module ddrmc_ctrl_bench;
	reg          clk, rst, cyc, stb, we, ddr3, ch_en, ch_cap, hprot, sr_exit, lclk;
	reg  [7:0]   adr;
	reg  [31:0]  dat;
	reg  [1:0]   dead;
	wire [31:0]  dat_o;
	wire         ack, buff, split_en, zqcs, zqcl, dll_upd;
	wire [2:0]   drive;
	wire [1:0]   dqs_en, busy, fb;
	wire [6:0]   dly0, dly1;
	int          bad_count, n_compared, run, len, wlo;
	logic [31:0] expq[$];

	ddrmc_ctrl #(.UPDATE_UNIT(8)) DUT (
		.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
		.SEL_I(4'hf), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .DDR3_MODE(ddr3),
		.CH1_ENABLE(ch_en), .CH1_SPLIT_CAP(ch_cap), .CH1_HPROT_BUF(hprot),
		.SR_EXIT(sr_exit), .WL_DQ_FB(fb), .CH1_BUFFERABLE(buff), .CH1_SPLIT_EN(split_en),
		.ZQCS_REQ(zqcs), .ZQCL_REQ(zqcl), .DLL_UPD_REQ(dll_upd), .PHY_DRIVE(drive),
		.WL_DQS_EN(dqs_en), .WL_BUSY(busy), .LANE0_DELAY(dly0), .LANE1_DELAY(dly1));
	ddrmc_dram_model u_dram (.lclk(lclk), .dqs_en(dqs_en), .dly0(dly0), .dly1(dly1),
		.dead(dead), .fb(fb));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'h1 && k < 20);
		cyc <= 1'h0;
		stb <= 1'h0;
		if (k >= 20) begin
			bad_count++;
			close_out;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(1'h0, a, 32'h0);
	endtask

	task automatic settle;
		int k = 0;
		repeat (4) @(posedge clk);
		while (busy !== 2'h0 && k < 9000) begin
			@(posedge clk);
			k++;
		end
		chk(busy, 0);
	endtask

	// one queue serves read data and zq pulses; they never overlap in time
	always @(posedge clk) begin
		if ((ack === 1'h1 && !we) || zqcs === 1'h1 || zqcl === 1'h1)
			chk((ack === 1'h1 && !we) ? dat_o : {23'h0, 1'h1, 6'h0, zqcl, zqcs},
				expq.size() ? expq.pop_front() : 'x);
		if (dqs_en[0] === 1'h1)
			len++;
		else if (len > 0) begin
			chk(len, wlo);
			len = 0;
		end
	end

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		lclk = 1'h0;
		#37;
		forever #400 lclk = ~lclk;
	end
	initial begin
		#4000000;
		bad_count++;
		close_out;
	end

	initial begin
		{cyc, stb, we, ddr3, ch_en, ch_cap, hprot, sr_exit} = 8'h0;
		rst = 1'h1;
		adr = 8'h0;
		dat = 32'h0;
		dead = 2'h0;
		len = 0;
		wlo = 32;
		void'($urandom(32'h1494));
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		rd(8'h48, 32'h0);
		rd(8'h4c, 32'h0);
		rd(8'h5c, 32'h7);
		rd(8'h60, 32'ha);
		wb(1'h1, 8'h50, 32'hffffffff);
		rd(8'h50, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wb(1'h1, 8'h5c, ($urandom & 32'hfffffff8) | i);
			rd(8'h5c, i);
			chk(drive, i);
		end
		for (int i = 0; i < 32; i++) begin
			hprot <= 1'($urandom);
			ch_en <= i[3];
			ch_cap <= i[4];
			wb(1'h1, 8'h48, {22'h0, i[1:0], 6'h0, i[2], 1'h0});
			repeat (3) @(posedge clk);
			chk(buff, i[1:0] == 2'h1 || (i[1:0] != 2'h2 && hprot));
			chk(split_en, i[3] && i[4] && !i[2]);
		end
		for (int i = 0; i < 4; i++) begin
			wb(1'h1, 8'h4c, i << 16);
			if (i == 1 || i == 2)
				expq.push_back(32'h100 + i);
			sr_exit <= 1'h1;
			@(posedge clk);
			sr_exit <= 1'h0;
			repeat (6) @(posedge clk);
			rd(8'h4c, i << 16);
		end
		for (int n = 0; n < 3; n++) begin
			wb(1'h1, 8'h4c, n);
			// let the interval counter settle into its new period first
			repeat (24) @(posedge clk);
			run = 0;
			repeat (96) begin
				@(posedge clk);
				run += dll_upd;
			end
			chk(run, n ? 12 / n : 0);
		end
		wb(1'h1, 8'h4c, 32'h100);
		wb(1'h1, 8'h60, 32'h20);
		run = 0;
		repeat (40) begin
			@(posedge clk);
			run |= busy;
		end
		chk(run, 0);
		ddr3 <= 1'h1;
		run = 0;
		while (busy === 2'h0 && run < 30) begin
			@(posedge clk);
			run++;
		end
		chk(busy, 2'h3);
		wb(1'h1, 8'h4c, 32'h0);
		settle;
		rd(8'h60, 32'h03000020);
		chk(dly0, 7'h14);
		chk(dly1, 7'h2d);
		dead <= 2'h1;
		wlo = 33;
		wb(1'h1, 8'h60, 32'h03020021);
		settle;
		rd(8'h60, 32'h00020021);
		chk(dly0, 7'h7f);
		wb(1'h1, 8'h64, 32'h00002d00);
		close_out;
	end
endmodule
